// [rtl/dpi_ctrl.sv]
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dpi_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // phy and memory side
  input wire logic i_mem_temp_flag,
  input wire logic [1:0] i_strobe_drift,
  input wire logic i_train_done,
  input wire logic i_train_fail,
  input wire logic i_train_pass,
  input wire logic i_imp_cal_done,
  input wire logic i_master_lock,
  input wire logic [7:0] i_dll_dig_master,
  input wire logic [7:0] i_dll_dig_slave,
  input wire logic [3:0] i_dll_ana_master,
  input wire logic [3:0] i_dll_ana_slave,
  output logic o_dll_dig_test,
  output logic o_dll_ana_test,
  output logic o_dll_ana_test_oe,
  output logic o_dll_disable_bypass,
  output logic o_dll_soft_reset,
  output logic o_slave_dll_loopback,
  output logic [7:0] o_slave_phase_deg,
  output logic o_slave_auto_start,
  output logic o_slave_pd_en,
  output logic o_itm_reset,
  output logic o_mem_reset_n,
  output logic o_mem_cke,
  output logic o_zq_init,
  output logic o_imp_cal_start,
  output logic o_train_start
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0] init_reg, gcfg_reg, dllgc_reg, acdll_reg, ptr0_reg, ptr1_reg, ptr2_reg, acio_reg;
  logic [7:0] status_reg;
  logic [18:0] cnt_reg;
  logic [7:0] steps_reg;
  logic dll_srst_reg, train_seen_fail_reg, train_seen_pass_reg;
  dpi_pkg::dpi_state_t state_reg;
  logic wr, rd_ack;
  logic [31:0] wmask;
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign rd_ack = i_wb_cyc & i_wb_stb & ~o_wb_ack;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m);
    merge = ((old & ~wmask) | (i_wb_dat & wmask)) & m;
  endfunction

  // ****************************************
  // bus: one wait state, ack one cycle
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= rd_ack;
      case (i_wb_adr)
        dpi_pkg::OFS_INIT: o_wb_dat <= init_reg;
        dpi_pkg::OFS_GCFG: o_wb_dat <= gcfg_reg;
        dpi_pkg::OFS_STATUS: o_wb_dat <= {i_mem_temp_flag, 23'h000000, status_reg};
        dpi_pkg::OFS_DLLGC: o_wb_dat <= dllgc_reg;
        dpi_pkg::OFS_ACDLL: o_wb_dat <= acdll_reg;
        dpi_pkg::OFS_PTR0: o_wb_dat <= ptr0_reg;
        dpi_pkg::OFS_PTR1: o_wb_dat <= ptr1_reg;
        dpi_pkg::OFS_PTR2: o_wb_dat <= ptr2_reg;
        dpi_pkg::OFS_ACIO: o_wb_dat <= acio_reg;
        default: o_wb_dat <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      gcfg_reg <= 32'h0000_0000;
      dllgc_reg <= dpi_pkg::RST_DLLGC;
      acdll_reg <= dpi_pkg::RST_ACDLL;
      ptr0_reg <= dpi_pkg::RST_PTR0;
      ptr1_reg <= dpi_pkg::RST_PTR1;
      ptr2_reg <= dpi_pkg::RST_PTR2;
      acio_reg <= dpi_pkg::RST_ACIO;
    end else if (wr) begin
      case (i_wb_adr)
        dpi_pkg::OFS_GCFG: gcfg_reg <= merge(gcfg_reg, 32'hFFFF_FFFF);
        dpi_pkg::OFS_DLLGC: dllgc_reg <= merge(dllgc_reg, dpi_pkg::MASK_DLLGC);
        dpi_pkg::OFS_ACDLL: acdll_reg <= merge(acdll_reg, dpi_pkg::MASK_ACDLL);
        dpi_pkg::OFS_PTR0: ptr0_reg <= merge(ptr0_reg, dpi_pkg::MASK_PTR0);
        dpi_pkg::OFS_PTR1: ptr1_reg <= merge(ptr1_reg, dpi_pkg::MASK_PTR12);
        dpi_pkg::OFS_PTR2: ptr2_reg <= merge(ptr2_reg, dpi_pkg::MASK_PTR12);
        dpi_pkg::OFS_ACIO: acio_reg <= merge(acio_reg, 32'hFFFF_FFFF);
        default: ;
      endcase
    end
  end

  // ****************************************
  // init sequencer
  // ****************************************
  logic trig;
  logic [3:0] itm_cycles;
  assign trig = wr && i_wb_adr == dpi_pkg::OFS_INIT && i_wb_sel[0]
    && i_wb_dat[dpi_pkg::B_TRIG] && state_reg == dpi_pkg::DPI_IDLE;
  // software must keep this at 8 or more; clamp guards a bad value
  assign itm_cycles = (ptr0_reg[21:18] < dpi_pkg::ITM_MIN) ? dpi_pkg::ITM_MIN : ptr0_reg[21:18];

  // next step after a given one, skipping unselected steps
  function automatic dpi_pkg::dpi_state_t next_step(input logic [7:0] s, input int from);
    next_step = dpi_pkg::DPI_IDLE;
    for (int k = 7; k >= 1; k--) begin
      if (k >= from && s[k]) begin
        case (k)
          1: next_step = dpi_pkg::DPI_DLLRST;
          2: next_step = dpi_pkg::DPI_LOCK;
          3: next_step = dpi_pkg::DPI_ZCAL;
          4: next_step = dpi_pkg::DPI_ITM;
          5: next_step = dpi_pkg::DPI_MEMRST;
          6: next_step = dpi_pkg::DPI_CKE0;
          default: next_step = dpi_pkg::DPI_TRAIN;
        endcase
      end
    end
  endfunction

  // counter load per step
  function automatic logic [18:0] load_for(input dpi_pkg::dpi_state_t st);
    case (st)
      dpi_pkg::DPI_DLLRST: load_for = {13'h0000, ptr0_reg[5:0]};
      dpi_pkg::DPI_LOCK: load_for = {7'h00, ptr0_reg[17:6]};
      dpi_pkg::DPI_ITM: load_for = {15'h0000, itm_cycles};
      dpi_pkg::DPI_MEMRST: load_for = {2'h0, ptr2_reg[16:0]};
      dpi_pkg::DPI_CKE0: load_for = ptr1_reg[18:0];
      dpi_pkg::DPI_CKE1: load_for = {11'h000, ptr1_reg[26:19]};
      dpi_pkg::DPI_ZQ: load_for = {9'h000, ptr2_reg[26:17]};
      default: load_for = 19'h00000;
    endcase
  endfunction

  logic cnt_zero;
  dpi_pkg::dpi_state_t nxt;
  assign cnt_zero = cnt_reg <= 19'h00001;
  always_comb begin
    nxt = state_reg;
    case (state_reg)
      dpi_pkg::DPI_IDLE: if (trig) nxt = next_step({i_wb_dat[7:1], 1'b0}, 1);
      dpi_pkg::DPI_DLLRST: if (cnt_zero) nxt = next_step(steps_reg, 2);
      dpi_pkg::DPI_LOCK: if (cnt_zero) nxt = next_step(steps_reg, 3);
      dpi_pkg::DPI_ZCAL: if (i_imp_cal_done) nxt = next_step(steps_reg, 4);
      dpi_pkg::DPI_ITM: if (cnt_zero) nxt = next_step(steps_reg, 5);
      dpi_pkg::DPI_MEMRST: if (cnt_zero) nxt = next_step(steps_reg, 6);
      dpi_pkg::DPI_CKE0: if (cnt_zero) nxt = dpi_pkg::DPI_CKE1;
      dpi_pkg::DPI_CKE1: if (cnt_zero) nxt = gcfg_reg[dpi_pkg::B_LPDDR2] ?
        dpi_pkg::DPI_ZQ : next_step(steps_reg, 7);
      dpi_pkg::DPI_ZQ: if (cnt_zero) nxt = next_step(steps_reg, 7);
      dpi_pkg::DPI_TRAIN: if (i_train_done) nxt = dpi_pkg::DPI_IDLE;
      default: nxt = dpi_pkg::DPI_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_reg <= dpi_pkg::DPI_IDLE;
      cnt_reg <= 19'h00000;
      steps_reg <= 8'h00;
      init_reg <= 32'h0000_0000;
    end else begin
      state_reg <= nxt;
      if (nxt != state_reg) cnt_reg <= load_for(nxt);
      else if (cnt_reg != 19'h00000) cnt_reg <= cnt_reg - 19'h00001;
      if (trig) begin
        steps_reg <= {i_wb_dat[7:1], 1'b0};
        init_reg <= {24'h000000, i_wb_dat[7:1], 1'b0};
      end else if (wr && i_wb_adr == dpi_pkg::OFS_INIT && i_wb_sel[0]) begin
        init_reg <= {24'h000000, i_wb_dat[7:1], 1'b0};
      end
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  logic drift_hit;
  assign drift_hit = gcfg_reg[4:3] != 2'b00 && i_strobe_drift >= gcfg_reg[4:3];
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      status_reg <= 8'h00;
      train_seen_fail_reg <= 1'b0;
      train_seen_pass_reg <= 1'b0;
    end else begin
      if (trig) status_reg <= 8'h00;
      if (drift_hit) status_reg[dpi_pkg::B_DRIFT] <= 1'b1;
      if (state_reg == dpi_pkg::DPI_LOCK && cnt_zero) status_reg[dpi_pkg::B_DLL_LOCK_DONE] <= 1'b1;
      if (state_reg == dpi_pkg::DPI_ZCAL && i_imp_cal_done)
        status_reg[dpi_pkg::B_IMP_CAL_DONE] <= 1'b1;
      if (state_reg == dpi_pkg::DPI_CKE1 && cnt_zero && !gcfg_reg[dpi_pkg::B_LPDDR2])
        status_reg[dpi_pkg::B_MEM_INIT_DONE] <= 1'b1;
      if (state_reg == dpi_pkg::DPI_ZQ && cnt_zero) status_reg[dpi_pkg::B_MEM_INIT_DONE] <= 1'b1;
      if (state_reg == dpi_pkg::DPI_TRAIN) begin
        if (i_train_pass) train_seen_pass_reg <= 1'b1;
        if (i_train_fail && train_seen_pass_reg) train_seen_fail_reg <= 1'b1;
        if (i_train_pass && train_seen_fail_reg)
          status_reg[dpi_pkg::B_TIERR] <= 1'b1;
        if (i_train_done) begin
          status_reg[dpi_pkg::B_TDONE] <= 1'b1;
          if (!train_seen_pass_reg && !i_train_pass) status_reg[dpi_pkg::B_TERR] <= 1'b1;
        end
      end else begin
        train_seen_pass_reg <= 1'b0;
        train_seen_fail_reg <= 1'b0;
      end
      if (state_reg != dpi_pkg::DPI_IDLE && nxt == dpi_pkg::DPI_IDLE)
        status_reg[dpi_pkg::B_ALL_INIT_DONE] <= 1'b1;
      else if (trig && i_wb_dat[7:1] == 7'h00)
        status_reg[dpi_pkg::B_ALL_INIT_DONE] <= 1'b1;
    end
  end

  // ****************************************
  // dll test and control outputs
  // ****************************************
  logic [7:0] dig_src;
  logic [3:0] ana_src;
  logic [3:0] ph;
  assign dig_src = dllgc_reg[dpi_pkg::B_TESTSEL] ? i_dll_dig_slave : i_dll_dig_master;
  assign ana_src = dllgc_reg[dpi_pkg::B_TESTSEL] ? i_dll_ana_slave : i_dll_ana_master;
  assign ph = acdll_reg[dpi_pkg::B_PHASE_LO +: 4];
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_dll_dig_test <= 1'b0;
      o_dll_ana_test <= 1'b0;
      o_dll_ana_test_oe <= 1'b0;
      o_slave_phase_deg <= 8'h5A;
      dll_srst_reg <= 1'b0;
      o_itm_reset <= 1'b0;
      o_mem_reset_n <= 1'b1;
      o_mem_cke <= 1'b0;
      o_zq_init <= 1'b0;
      o_imp_cal_start <= 1'b0;
      o_train_start <= 1'b0;
    end else begin
      o_dll_dig_test <= dllgc_reg[dpi_pkg::B_DLL_TEST_EN] &
        dig_src[dllgc_reg[dpi_pkg::B_DTC_LO +: 3]];
      // low while test disabled stands in for ground
      o_dll_ana_test <= dllgc_reg[dpi_pkg::B_DLL_TEST_EN] &
        ana_src[dllgc_reg[dpi_pkg::B_ATC_LO +: 2]];
      o_dll_ana_test_oe <= acdll_reg[dpi_pkg::B_ANALOG_TEST_OUT_EN];
      // 90 + 18*(ph[3:2]) - 18*(ph[1:0])
      o_slave_phase_deg <= 8'(8'h5A + 8'h12 * {6'h00, ph[3:2]} - 8'h12 * {6'h00, ph[1:0]});
      dll_srst_reg <= nxt == dpi_pkg::DPI_DLLRST;
      o_itm_reset <= nxt == dpi_pkg::DPI_ITM;
      o_mem_reset_n <= nxt != dpi_pkg::DPI_MEMRST;
      o_mem_cke <= (nxt == dpi_pkg::DPI_CKE0) ? gcfg_reg[dpi_pkg::B_LPDDR2] :
        (nxt == dpi_pkg::DPI_CKE1) ? !gcfg_reg[dpi_pkg::B_LPDDR2] :
        (nxt == dpi_pkg::DPI_ZQ || o_mem_cke);
      o_zq_init <= state_reg == dpi_pkg::DPI_CKE1 && nxt == dpi_pkg::DPI_ZQ;
      o_imp_cal_start <= state_reg != dpi_pkg::DPI_ZCAL && nxt == dpi_pkg::DPI_ZCAL;
      o_train_start <= state_reg != dpi_pkg::DPI_TRAIN && nxt == dpi_pkg::DPI_TRAIN;
    end
  end
  assign o_dll_disable_bypass = acdll_reg[dpi_pkg::B_DLL_DISABLE_BYPASS];
  assign o_dll_soft_reset = acdll_reg[dpi_pkg::B_DLL_SOFT_RESET] | dll_srst_reg;
  assign o_slave_dll_loopback = acdll_reg[dpi_pkg::B_LOOPB];
  assign o_slave_auto_start = ~acdll_reg[dpi_pkg::B_SLAVE_STARTUP_CTL_LO + 1] & i_master_lock;
  assign o_slave_pd_en = ~acdll_reg[dpi_pkg::B_SLAVE_STARTUP_CTL_LO + 1] | acdll_reg[dpi_pkg::B_SLAVE_STARTUP_CTL_LO];

  // ****************************************
  // assertions
  // ****************************************
  a_ack_one_cycle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
  a_dll_rst_state: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_reg == dpi_pkg::DPI_DLLRST |-> o_dll_soft_reset) else $error("dll reset not driven");
  a_itm_min_len: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_itm_reset) |-> o_itm_reset[*8]) else $error("itm reset too short");
  a_all_init_done_end: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_reg != dpi_pkg::DPI_IDLE && nxt == dpi_pkg::DPI_IDLE |=> status_reg[0])
    else $error("init done missing");
  a_test_off_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !dllgc_reg[dpi_pkg::B_DLL_TEST_EN] |=> !o_dll_dig_test && !o_dll_ana_test)
    else $error("test output leaked");
  a_drift_sets: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    drift_hit |=> status_reg[dpi_pkg::B_DRIFT]) else $error("drift flag missing");
  a_ana_tristate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 o_dll_ana_test_oe == $past(acdll_reg[dpi_pkg::B_ANALOG_TEST_OUT_EN])) else $error("analog oe wrong");
  a_memrst_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_reg == dpi_pkg::DPI_MEMRST && !cnt_zero |=> !o_mem_reset_n) else $error("reset not low");
  a_train_done: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_reg == dpi_pkg::DPI_TRAIN && i_train_done |=> status_reg[dpi_pkg::B_TDONE])
    else $error("train done missing");
  a_lock_done: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    state_reg == dpi_pkg::DPI_LOCK && cnt_zero |=> status_reg[dpi_pkg::B_DLL_LOCK_DONE])
    else $error("lock done missing");
  c_zq_cmd: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_zq_init);
  c_train_err: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(status_reg[dpi_pkg::B_TERR]));
  c_full_init: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    state_reg == dpi_pkg::DPI_TRAIN ##1 state_reg == dpi_pkg::DPI_IDLE);
  c_lock: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(status_reg[1]));
  c_write: cover property (@(posedge i_clk) disable iff (!i_reset_n) wr ##1 o_wb_ack);
endmodule
`default_nettype wire

// [common/dpi_pkg.sv]
package dpi_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_INIT = 8'h04;
  localparam logic [7:0] OFS_GCFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DLLGC = 8'h10;
  localparam logic [7:0] OFS_ACDLL = 8'h14;
  localparam logic [7:0] OFS_PTR0 = 8'h18;
  localparam logic [7:0] OFS_PTR1 = 8'h1C;
  localparam logic [7:0] OFS_PTR2 = 8'h20;
  localparam logic [7:0] OFS_ACIO = 8'h24;
  // ****************************************
  // reset values and write masks
  // ****************************************
  localparam logic [31:0] RST_DLLGC = 32'h0373_7000;
  localparam logic [31:0] RST_ACDLL = 32'h4000_0000;
  localparam logic [31:0] RST_PTR0 = 32'h0022_AF9B;
  localparam logic [31:0] RST_PTR1 = 32'h0604_111D;
  localparam logic [31:0] RST_PTR2 = 32'h042D_A072;
  localparam logic [31:0] RST_ACIO = 32'h0000_0000;
  localparam logic [31:0] MASK_DLLGC = 32'h2FFF_FFFF;
  localparam logic [31:0] MASK_ACDLL = 32'hC00F_FFFF;
  localparam logic [31:0] MASK_PTR0 = 32'h003F_FFFF;
  localparam logic [31:0] MASK_PTR12 = 32'h07FF_FFFF;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_TRIG = 0;
  localparam int B_SEL_DLLRST = 1;
  localparam int B_SEL_LOCK = 2;
  localparam int B_SEL_ZCAL = 3;
  localparam int B_SEL_ITM = 4;
  localparam int B_SEL_MEMRST = 5;
  localparam int B_SEL_DINIT = 6;
  localparam int B_SEL_TRAIN = 7;
  localparam int B_TEMP = 31;
  localparam int B_DRIFT = 7;
  localparam int B_TIERR = 6;
  localparam int B_TERR = 5;
  localparam int B_TDONE = 4;
  localparam int B_MEM_INIT_DONE = 3;
  localparam int B_IMP_CAL_DONE = 2;
  localparam int B_DLL_LOCK_DONE = 1;
  localparam int B_ALL_INIT_DONE = 0;
  localparam int B_TESTSEL = 11;
  localparam int B_DLL_TEST_EN = 5;
  localparam int B_DTC_LO = 6;
  localparam int B_ATC_LO = 9;
  localparam int B_DLL_DISABLE_BYPASS = 31;
  localparam int B_DLL_SOFT_RESET = 30;
  localparam int B_LOOPB = 19;
  localparam int B_ANALOG_TEST_OUT_EN = 18;
  localparam int B_PHASE_LO = 14;
  localparam int B_SLAVE_STARTUP_CTL_LO = 12;
  localparam int B_DRIFT_LIMIT_LO = 3;
  localparam int B_LPDDR2 = 31;
  localparam logic [3:0] ITM_MIN = 4'h8;
  typedef enum logic [9:0] {
    DPI_IDLE = 10'h001,
    DPI_DLLRST = 10'h002,
    DPI_LOCK = 10'h004,
    DPI_ZCAL = 10'h008,
    DPI_ITM = 10'h010,
    DPI_MEMRST = 10'h020,
    DPI_CKE0 = 10'h040,
    DPI_CKE1 = 10'h080,
    DPI_ZQ = 10'h100,
    DPI_TRAIN = 10'h200
  } dpi_state_t;
endpackage

// [tb/dpi_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dpi_mem_model (
  // clock
  input wire logic i_clk,
  // requests from the controller; trial mode from the testbench
  input wire logic i_dll_soft_reset,
  input wire logic i_imp_cal_start,
  input wire logic i_train_start,
  input wire logic [1:0] i_train_mode,
  // answers
  output logic o_master_lock,
  output logic o_imp_cal_done,
  output logic o_train_pass,
  output logic o_train_fail,
  output logic o_train_done
);
  logic [2:0] lock_sr = 3'h0;
  logic [3:0] cal_sr = 4'h0;
  logic [5:0] trn_sr = 6'h0;
  logic [1:0] mode_reg = 2'h0;
  // lock is lost at once in reset, regained three cycles after release
  always @(posedge i_clk) begin
    lock_sr <= i_dll_soft_reset ? 3'h0 : {lock_sr[1:0], 1'b1};
    cal_sr <= {cal_sr[2:0], i_imp_cal_start};
    trn_sr <= {trn_sr[4:0], i_train_start};
    if (i_train_start) begin
      mode_reg <= i_train_mode;
    end
  end
  assign o_master_lock = lock_sr[2];
  assign o_imp_cal_done = cal_sr[3];
  // trials: mode 0 pass, mode 1 pass fail pass, mode 2 fail only
  assign o_train_pass = (trn_sr[1] && mode_reg != 2'h2) || (trn_sr[3] && mode_reg == 2'h1);
  assign o_train_fail = trn_sr[2] && mode_reg != 2'h0;
  assign o_train_done = trn_sr[5];
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic i_clk, i_reset_n, i_wb_cyc, i_wb_stb, i_wb_we, i_mem_temp_flag, o_wb_ack;
  logic [7:0] i_wb_adr, i_dll_dig_master, i_dll_dig_slave, o_slave_phase_deg;
  logic [3:0] i_wb_sel, i_dll_ana_master, i_dll_ana_slave;
  logic [31:0] i_wb_dat, o_wb_dat, rd, v;
  logic [1:0] i_strobe_drift, mode;
  logic i_train_done, i_train_fail, i_train_pass, i_imp_cal_done, i_master_lock;
  logic o_dll_dig_test, o_dll_ana_test, o_dll_ana_test_oe, o_dll_disable_bypass;
  logic o_dll_soft_reset, o_slave_dll_loopback, o_slave_auto_start, o_slave_pd_en;
  logic o_itm_reset, o_mem_reset_n, o_mem_cke, o_zq_init, o_imp_cal_start, o_train_start;
  logic e_dig, e_ana;
  logic [2:0] mon;
  int fails, checks_done, cycles, seed, zq_cnt;
  int run [3];
  int wid [3];
  localparam logic [7:0] reg_ofs [7] = '{dpi_pkg::OFS_DLLGC, dpi_pkg::OFS_ACDLL,
    dpi_pkg::OFS_PTR0, dpi_pkg::OFS_PTR1, dpi_pkg::OFS_PTR2, dpi_pkg::OFS_ACIO,
    dpi_pkg::OFS_STATUS};
  localparam logic [31:0] reg_rst [7] = '{dpi_pkg::RST_DLLGC, dpi_pkg::RST_ACDLL,
    dpi_pkg::RST_PTR0, dpi_pkg::RST_PTR1, dpi_pkg::RST_PTR2, dpi_pkg::RST_ACIO, 32'h0};
  localparam logic [31:0] reg_msk [7] = '{dpi_pkg::MASK_DLLGC, dpi_pkg::MASK_ACDLL,
    dpi_pkg::MASK_PTR0, dpi_pkg::MASK_PTR12, dpi_pkg::MASK_PTR12, 32'hFFFF_FFFF, 32'h0};

  dpi_ctrl dut (.i_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_mem_temp_flag, .i_strobe_drift, .i_train_done,
    .i_train_fail, .i_train_pass, .i_imp_cal_done, .i_master_lock, .i_dll_dig_master,
    .i_dll_dig_slave, .i_dll_ana_master, .i_dll_ana_slave, .o_dll_dig_test, .o_dll_ana_test,
    .o_dll_ana_test_oe, .o_dll_disable_bypass, .o_dll_soft_reset, .o_slave_dll_loopback,
    .o_slave_phase_deg, .o_slave_auto_start, .o_slave_pd_en, .o_itm_reset, .o_mem_reset_n,
    .o_mem_cke, .o_zq_init, .o_imp_cal_start, .o_train_start);

  dpi_mem_model mem (.i_clk(i_clk), .i_dll_soft_reset(o_dll_soft_reset),
    .i_imp_cal_start(o_imp_cal_start), .i_train_start(o_train_start), .i_train_mode(mode),
    .o_master_lock(i_master_lock), .o_imp_cal_done(i_imp_cal_done),
    .o_train_pass(i_train_pass), .o_train_fail(i_train_fail), .o_train_done(i_train_done));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ****************************************
  // pulse width monitor and timeout
  // ****************************************
  always @(posedge i_clk) begin
    cycles++;
    mon = {o_itm_reset, o_dll_soft_reset, ~o_mem_reset_n};
    for (int k = 0; k < 3; k++) begin
      if (mon[k] === 1'b1) begin
        run[k]++;
      end else if (run[k] != 0) begin
        wid[k] = run[k];
        run[k] = 0;
      end
    end
    if (o_zq_init === 1'b1) zq_cnt++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // classic cycle; never assumes the wait-state count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 40);
    rd = o_wb_dat;
    if (o_wb_ack !== 1'b1) chk(32'h0, 32'h1, "no ack");
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic run_seq(input logic [7:0] steps, input logic [31:0] exp_st);
    int n;
    bus(1'b1, dpi_pkg::OFS_INIT, {24'h0, steps | 8'h01});
    n = 0;
    do begin
      bus(1'b0, dpi_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 300);
    chk(rd, exp_st, "status after init");
    $display("test init steps %h done, mismatches %0d", steps, fails);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] phase_deg(input logic [3:0] c);
    return 8'h5A + 8'h12 * c[3:2] - 8'h12 * c[1:0];
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h996C;
    {fails, checks_done, cycles, zq_cnt} = '0;
    run = '{0, 0, 0};
    wid = '{0, 0, 0};
    {i_reset_n, i_wb_cyc, i_wb_stb, i_wb_we, i_mem_temp_flag} = '0;
    {i_wb_adr, i_wb_dat, i_strobe_drift, mode} = '0;
    i_wb_sel = 4'hF;
    {i_dll_dig_master, i_dll_dig_slave, i_dll_ana_master, i_dll_ana_slave} = 24'($random(seed));
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    chk({28'h0, o_dll_soft_reset, o_mem_reset_n, o_mem_cke, o_wb_ack}, 32'hC, "pins");
    chk({24'h0, o_slave_phase_deg}, 32'h5A, "phase at reset");
    for (int k = 0; k < 7; k++) begin
      bus(1'b0, reg_ofs[k], 32'h0);
      chk(rd, reg_rst[k], "reset value");
      v = $random(seed);
      bus(1'b1, reg_ofs[k], v);
      bus(1'b0, reg_ofs[k], 32'h0);
      chk(rd, (v & reg_msk[k]) | (reg_rst[k] & ~reg_msk[k]), "readback");
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped");
    $display("test registers done, mismatches %0d", fails);
    for (int k = 0; k < 16; k++) begin
      v = $random(seed);
      v[17:14] = k[3:0];
      bus(1'b1, dpi_pkg::OFS_ACDLL, v);
      repeat (5) @(posedge i_clk);
      chk({24'h0, o_slave_phase_deg}, {24'h0, phase_deg(v[17:14])}, "phase");
      chk({28'h0, o_dll_disable_bypass, o_dll_soft_reset, o_slave_dll_loopback,
        o_dll_ana_test_oe}, {28'h0, v[31:30], v[19:18]}, "dll pins");
      chk({30'h0, o_slave_auto_start, o_slave_pd_en},
        {30'h0, ~v[13] & i_master_lock, ~v[13] | v[12]}, "startup");
      v = $random(seed) & dpi_pkg::MASK_DLLGC;
      bus(1'b1, dpi_pkg::OFS_DLLGC, v);
      {i_dll_dig_master, i_dll_dig_slave, i_dll_ana_master, i_dll_ana_slave} <= 24'($random(seed));
      i_mem_temp_flag <= k[0] ^ k[2];
      repeat (3) @(posedge i_clk);
      e_dig = v[11] ? i_dll_dig_slave[v[8:6]] : i_dll_dig_master[v[8:6]];
      e_ana = v[11] ? i_dll_ana_slave[v[10:9]] : i_dll_ana_master[v[10:9]];
      chk({30'h0, o_dll_dig_test, o_dll_ana_test},
        {30'h0, v[5] & e_dig, v[5] & e_ana}, "test out");
      bus(1'b0, dpi_pkg::OFS_STATUS, 32'h0);
      chk({31'h0, rd[31]}, {31'h0, i_mem_temp_flag}, "temp");
    end
    $display("test dll controls done, mismatches %0d", fails);
    i_mem_temp_flag <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      i_strobe_drift <= 2'h0;
      bus(1'b1, dpi_pkg::OFS_GCFG, {27'h0, k[1:0], 3'h0});
      bus(1'b1, dpi_pkg::OFS_INIT, 32'h1);
      i_strobe_drift <= k[3:2];
      repeat (3) @(posedge i_clk);
      bus(1'b0, dpi_pkg::OFS_STATUS, 32'h0);
      chk({30'h0, rd[7], rd[0]}, {30'h0, k[1:0] != 0 && k[3:2] >= k[1:0], 1'b1}, "drift");
    end
    $display("test drift done, mismatches %0d", fails);
    i_strobe_drift <= 2'h0;
    bus(1'b1, dpi_pkg::OFS_ACDLL, 32'h0);
    bus(1'b1, dpi_pkg::OFS_GCFG, 32'h0);
    bus(1'b1, dpi_pkg::OFS_PTR0, {10'h0, 4'h9, 12'h006, 6'h09});
    bus(1'b1, dpi_pkg::OFS_PTR1, {5'h0, 8'h04, 19'h00005});
    bus(1'b1, dpi_pkg::OFS_PTR2, {5'h0, 10'h003, 17'h00007});
    mode <= 2'h1;
    run_seq(8'hFE, 32'h0000_005F);
    chk(wid[2], 32'h9, "itm width");
    chk(wid[1], 32'h9, "dll reset width");
    chk(wid[0], 32'h7, "mem reset width");
    chk({31'h0, o_mem_cke}, 32'h1, "cke");
    wid = '{0, 0, 0};
    bus(1'b1, dpi_pkg::OFS_PTR0, {10'h0, 4'hC, 12'h006, 6'h09});
    run_seq(8'h10, 32'h1);
    chk(wid[2], 32'hC, "itm width");
    chk(wid[1], 32'h0, "dll reset skipped");
    bus(1'b1, dpi_pkg::OFS_GCFG, 32'h8000_0000);
    zq_cnt = 0;
    run_seq(8'h40, 32'h9);
    chk(zq_cnt, 32'h1, "zq command");
    mode <= 2'h2;
    run_seq(8'h80, 32'h31);
    mode <= 2'h0;
    run_seq(8'h88, 32'h15);
    close_out();
  end
endmodule
`default_nettype wire
